/* core/ann_pkg.sv */
// Constants and register map of the eight-channel alarm annunciator
// Contract
// - Eight alarm channels, each set to fault on an opening or on a closing contact.
// - Each indication output follows its polarity-qualified input in real time.
// - One setting inverts all indication outputs.
// - A new fault blinks its channel light and raises the group relay and the alarm output.
// - An alarm stays latched after its fault goes away.
// - Only an acknowledge from the reset button or reset input clears a latched alarm; the code also clears it when the control acknowledge bit is written.
// - Acknowledge drops the group alarm and turns blinking lights steady until the input is normal.
// - Per-channel state lets new alarms blink while acknowledged, still-present ones stay lit.
// - A selectable input delay is the time a fault must persist before it raises an alarm.
// - A selectable delay separates alarm detection from the alarm output.
// - Input and output delays are common to all channels.
// - The delay settings cover 0.5 to 8 s for input and 0 to 15.5 s for output.
// - A test function exercises the indications and the alarm.
// - External test and reset inputs act like the local buttons so units can be grouped.
// - The group relay drive is energised in normal state and released during an alarm.
package ann_pkg;

  localparam int ANN_CH = 8;

  // Time base
  localparam int ANN_CLK_NS = 100;
  localparam int ANN_STEP_NS = 500000000; // Delay step and blink half period, 0.5 s
  localparam int ANN_STEP_CYC = ANN_STEP_NS / ANN_CLK_NS;

  // Register byte offsets
  localparam logic [7:0] ANN_OFF_CTRL = 8'h00;
  localparam logic [7:0] ANN_OFF_POL = 8'h04;
  localparam logic [7:0] ANN_OFF_DLY = 8'h08;
  localparam logic [7:0] ANN_OFF_STAT = 8'h0C;
  localparam logic [7:0] ANN_OFF_ISTAT = 8'h10;
  localparam logic [7:0] ANN_OFF_IMASK = 8'h14;

  // Control fields
  localparam int ANN_CTRL_INV = 0;
  localparam int ANN_CTRL_TIND = 1;
  localparam int ANN_CTRL_TEST = 2;
  localparam int ANN_CTRL_ACK = 3;

  // Delay fields: input delay is (field+1) steps, output delay is field steps
  localparam int ANN_DLY_IN_LSB = 0;
  localparam int ANN_DLY_OUT_LSB = 8;

  // Reset values
  localparam logic [2:0] ANN_CTRL_RST = 3'h0;
  localparam logic [7:0] ANN_POL_RST = 8'h00;
  localparam logic [3:0] ANN_IDLY_RST = 4'h1;
  localparam logic [4:0] ANN_ODLY_RST = 5'h00;
  localparam logic [7:0] ANN_IMASK_RST = 8'h00;

  localparam logic [1:0] ANN_RESP_OK = 2'h0;
  localparam logic [1:0] ANN_RESP_ERR = 2'h2;

endpackage

/* core/ann_sync.sv */
// Two-stage synchroniser for pins entering the clock domain
`timescale 1ns/1ps
module ann_sync
  import ann_pkg::*;
#(
  parameter int W = 12
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

/* core/ann_tick.sv */
// Divider that gives a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module ann_tick
  import ann_pkg::*;
#(
  parameter int DIV = ANN_STEP_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  logic [W-1:0] cnt_reg;

  // Free-running count, pulse on wrap
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= '0;
      tick <= 1'h0;
    end
    else if (cnt_reg == W'(DIV - 1))
    begin
      cnt_reg <= '0;
      tick <= 1'h1;
    end
    else
    begin
      cnt_reg <= cnt_reg + W'(1);
      tick <= 1'h0;
    end
  end

endmodule

/* core/ann_top.sv */
// Alarm annunciator core with AXI4-Lite register access
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module ann_top
  import ann_pkg::*;
#(
  parameter int STEP_CYC = ANN_STEP_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ANN_CH-1:0] fault_in,
  input wire logic test_btn,
  input wire logic ext_test,
  input wire logic ack_btn,
  input wire logic ext_ack,
  output logic [ANN_CH-1:0] ind_out,
  output logic [ANN_CH-1:0] lamp_out,
  output logic alarm_out,
  output logic relay_drive,
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [ANN_CH+3:0] pin_s;
  logic step;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_ok;
  logic [2:0] ctrl_reg;
  logic sw_ack_reg;
  logic [ANN_CH-1:0] pol_reg;
  logic [3:0] idly_reg;
  logic [4:0] odly_reg;
  logic [ANN_CH-1:0] istat_reg;
  logic [ANN_CH-1:0] imask_reg;
  logic [ANN_CH-1:0] flt;
  logic test_lvl;
  logic ack_lvl;
  logic ack_prev_reg;
  logic ack_pulse;
  logic [3:0] dcnt_reg [ANN_CH];
  logic [ANN_CH-1:0] qual_reg;
  logic [ANN_CH-1:0] unack_reg;
  logic [ANN_CH-1:0] lit_reg;
  logic [ANN_CH-1:0] rise_evt;
  logic group;
  logic [4:0] ocnt_reg;
  logic blink_reg;

  // ****************************************************************
  // Pins and time base
  // ****************************************************************
  ann_sync #(
    .W(ANN_CH + 4)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({ext_ack, ack_btn, ext_test, test_btn, fault_in}),
    .q(pin_s)
  );

  ann_tick #(
    .DIV(STEP_CYC)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(step)
  );

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // Address and data are caught apart, so either may come first
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // Write channels and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'h1;
      s_axi_wready <= 1'h1;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= ANN_RESP_OK;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'h0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'h0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= wr_ok ? ANN_RESP_OK : ANN_RESP_ERR;
        s_axi_awready <= 1'h1;
        s_axi_wready <= 1'h1;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'h0;
    end
  end

  // Address decode for writes; the status word is read only but not an error
  always_comb
  begin
    unique case (aw_addr_reg)
      ANN_OFF_CTRL, ANN_OFF_POL, ANN_OFF_DLY, ANN_OFF_STAT, ANN_OFF_ISTAT, ANN_OFF_IMASK: wr_ok = 1'h1;
      default: wr_ok = 1'h0;
    endcase
  end

  // Read mux, unmapped words read zero with an error
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'h1;
    unique case (s_axi_araddr)
      ANN_OFF_CTRL: rd_data[2:0] = ctrl_reg;
      ANN_OFF_POL: rd_data[7:0] = pol_reg;
      ANN_OFF_DLY: rd_data = {19'h0, odly_reg, 4'h0, idly_reg};
      ANN_OFF_STAT: rd_data = {flt, 6'h00, alarm_out, group, lit_reg, unack_reg};
      ANN_OFF_ISTAT: rd_data[7:0] = istat_reg;
      ANN_OFF_IMASK: rd_data[7:0] = imask_reg;
      default: rd_ok = 1'h0;
    endcase
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ANN_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? ANN_RESP_OK : ANN_RESP_ERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'h0;
      s_axi_arready <= 1'h1;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Control and delay settings are shared by all channels, polarity and mask are per channel; acknowledge bit is a pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= ANN_CTRL_RST;
      sw_ack_reg <= 1'h0;
      pol_reg <= ANN_POL_RST;
      idly_reg <= ANN_IDLY_RST;
      odly_reg <= ANN_ODLY_RST;
      imask_reg <= ANN_IMASK_RST;
    end
    else
    begin
      sw_ack_reg <= wr_fire && aw_addr_reg == ANN_OFF_CTRL && w_strb_reg[0] && w_data_reg[ANN_CTRL_ACK];
      if (wr_fire && w_strb_reg[0])
      begin
        if (aw_addr_reg == ANN_OFF_CTRL)
          ctrl_reg <= w_data_reg[2:0];
        if (aw_addr_reg == ANN_OFF_POL)
          pol_reg <= w_data_reg[7:0];
        if (aw_addr_reg == ANN_OFF_DLY)
          idly_reg <= w_data_reg[ANN_DLY_IN_LSB +: 4];
        if (aw_addr_reg == ANN_OFF_IMASK)
          imask_reg <= w_data_reg[7:0];
      end
      if (wr_fire && w_strb_reg[1] && aw_addr_reg == ANN_OFF_DLY)
        odly_reg <= w_data_reg[ANN_DLY_OUT_LSB +: 5];
    end
  end

  // ****************************************************************
  // Input qualification
  // ****************************************************************
  // A set polarity bit makes a low (opening) input the fault
  assign flt = pin_s[ANN_CH-1:0] ^ pol_reg;
  // Buttons and the grouping inputs are ORed so parallel units act together
  assign test_lvl = pin_s[ANN_CH] | pin_s[ANN_CH+1] | ctrl_reg[ANN_CTRL_TEST];
  assign ack_lvl = pin_s[ANN_CH+2] | pin_s[ANN_CH+3];
  assign ack_pulse = (ack_lvl && !ack_prev_reg) || sw_ack_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ack_prev_reg <= 1'h0;
    else
      ack_prev_reg <= ack_lvl;
  end

  // Persistence filter; step granularity makes the wait idly..idly+1 steps
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      qual_reg <= '0;
      for (int i = 0; i < ANN_CH; i++)
        dcnt_reg[i] <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < ANN_CH; i++)
      begin
        if (!flt[i])
        begin
          dcnt_reg[i] <= 4'h0;
          qual_reg[i] <= 1'h0;
        end
        else if (step && !qual_reg[i])
        begin
          if (dcnt_reg[i] == idly_reg)
            qual_reg[i] <= 1'h1;
          else
            dcnt_reg[i] <= dcnt_reg[i] + 4'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Alarm latches
  // ****************************************************************
  // A channel already blinking or lit raises nothing new
  assign rise_evt = qual_reg & ~unack_reg & ~lit_reg;

  // Latch survives fault removal; only acknowledge moves it to steady
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unack_reg <= '0;
      lit_reg <= '0;
    end
    else
    begin
      unack_reg <= (unack_reg & ~{ANN_CH{ack_pulse}}) | rise_evt;
      lit_reg <= (lit_reg | (unack_reg & {ANN_CH{ack_pulse}})) & flt;
    end
  end

  // ****************************************************************
  // Group alarm and output delay
  // ****************************************************************
  // Test raises the group alarm unless it is set to indications only
  assign group = (|unack_reg) || (test_lvl && !ctrl_reg[ANN_CTRL_TIND]);

  // Output delay restarts whenever the group alarm drops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ocnt_reg <= 5'h00;
    else if (!group)
      ocnt_reg <= 5'h00;
    else if (step && ocnt_reg < odly_reg)
      ocnt_reg <= ocnt_reg + 5'h01;
  end

  // Relay is energised while healthy, so a dead supply also alarms
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alarm_out <= 1'h0;
      relay_drive <= 1'h1;
    end
    else
    begin
      alarm_out <= group && ocnt_reg >= odly_reg;
      relay_drive <= !(group && ocnt_reg >= odly_reg);
    end
  end

  // ****************************************************************
  // Lamps and indications
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      blink_reg <= 1'h0;
    else if (step)
      blink_reg <= !blink_reg;
  end

  // Test forces every lamp on and every indication to its fault level (low when inverted) without touching the latches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ind_out <= '0;
      lamp_out <= '0;
    end
    else
    begin
      ind_out <= (flt | {ANN_CH{test_lvl}}) ^ {ANN_CH{ctrl_reg[ANN_CTRL_INV]}};
      lamp_out <= (unack_reg & {ANN_CH{blink_reg}}) | lit_reg | {ANN_CH{test_lvl}};
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // New alarm sets win over a same-cycle write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      istat_reg <= '0;
      irq <= 1'h0;
    end
    else
    begin
      if (wr_fire && w_strb_reg[0] && aw_addr_reg == ANN_OFF_ISTAT)
        istat_reg <= (istat_reg & ~w_data_reg[7:0]) | rise_evt;
      else
        istat_reg <= istat_reg | rise_evt;
      irq <= |(istat_reg & imask_reg);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_RISE_LATCH: assert property ((|rise_evt) |=> (|unack_reg))
    else $error("raised alarm not latched");
  AST_LATCH_HOLD: assert property ((|($past(unack_reg) & ~unack_reg)) |-> $past(ack_pulse))
    else $error("alarm cleared without acknowledge");
  AST_ACK_ONLY: assert property (!ack_pulse && (|unack_reg) |=> (|unack_reg))
    else $error("latched alarm lost");
  AST_ACK_STEADY: assert property (ack_pulse && (|(unack_reg & flt)) ##1 (|flt) |-> (|lit_reg))
    else $error("acknowledged light not steady");
  AST_DIRECT_IND: assert property (!test_lvl && !ctrl_reg[ANN_CTRL_INV] |=> ind_out == $past(flt))
    else $error("indication does not follow input");
  AST_INVERT_IND: assert property (!test_lvl && ctrl_reg[ANN_CTRL_INV] |=> ind_out == ~$past(flt))
    else $error("indication not inverted");
  AST_FILTER: assert property (!flt[0] |=> !qual_reg[0])
    else $error("fault qualified without input");
  AST_NO_GROUP: assert property ((!group || ocnt_reg < odly_reg) |=> !alarm_out)
    else $error("alarm output before the output delay ran out");
  AST_FAILSAFE: assert property (relay_drive == !alarm_out)
    else $error("relay not fail-safe");
  AST_TEST_LAMPS: assert property (test_lvl |=> lamp_out == 8'hFF)
    else $error("test does not light all lamps");
  AST_IRQ: assert property ((|(istat_reg & imask_reg)) |=> irq)
    else $error("interrupt not raised");

  COV_RAISE: cover property ((|rise_evt) ##1 (|unack_reg));
  COV_ACK: cover property ((|unack_reg) && ack_pulse ##1 (|lit_reg));
  COV_OUT: cover property ($rose(alarm_out));
  COV_TEST: cover property (test_lvl ##1 lamp_out == 8'hFF);

endmodule

/* testbench/ann_field_model.sv */
// Field-side model: alarm contacts and operator push buttons
`timescale 1ns/1ps
module ann_field_model
#(
  parameter int HOLD_CYC = 4
)
(
  input wire logic aclk,
  input wire logic [7:0] want_fault,
  input wire logic [7:0] open_type,
  input wire logic press_test,
  input wire logic press_ack,
  input wire logic use_ext,
  output logic [7:0] fault_in,
  output logic test_btn,
  output logic ext_test,
  output logic ack_btn,
  output logic ext_ack
);
  int hold;

  // Idle field at power-up: contacts normal, buttons released
  initial
  begin
    hold = 0;
    fault_in = 8'h00;
    test_btn = 1'b0;
    ext_test = 1'b0;
    ack_btn = 1'b0;
    ext_ack = 1'b0;
  end

  // Opening-type contacts break on fault, closing-type ones make on fault
  always @(posedge aclk)
  begin
    fault_in <= want_fault ^ open_type;
  end

  // An acknowledge press is held a few cycles, as a finger would, a test press is not; group wire or panel button
  always @(posedge aclk)
  begin
    if (press_ack)
      hold <= HOLD_CYC;
    else if (hold > 0)
      hold <= hold - 1;
    ack_btn <= (press_ack || hold > 0) && !use_ext;
    ext_ack <= (press_ack || hold > 0) && use_ext;
    test_btn <= press_test && !use_ext;
    ext_test <= press_test && use_ext;
  end
endmodule

/* testbench/ann_tb_top.sv */
// Self-checking bench for the alarm annunciator core
`timescale 1ns/1ps
module ann_tb_top
  import ann_pkg::*;
;
  localparam int STEP = 20; // Short delay step keeps the run brief
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [7:0] fault_in;
  logic test_btn;
  logic ext_test;
  logic ack_btn;
  logic ext_ack;
  logic [7:0] ind_out;
  logic [7:0] lamp_out;
  logic alarm_out;
  logic relay_drive;
  logic irq;
  logic [7:0] want_fault;
  logic [7:0] open_type;
  logic press_test;
  logic press_ack;
  logic use_ext;
  logic [1:0] rsp;
  logic [31:0] rdat;
  int n;
  int hi;
  int n_mismatch;
  int checks;

  ann_top #(.STEP_CYC(STEP)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .fault_in(fault_in), .test_btn(test_btn), .ext_test(ext_test),
    .ack_btn(ack_btn), .ext_ack(ext_ack), .ind_out(ind_out), .lamp_out(lamp_out),
    .alarm_out(alarm_out), .relay_drive(relay_drive), .irq(irq));

  ann_field_model field (.aclk(aclk), .want_fault(want_fault), .open_type(open_type),
    .press_test(press_test), .press_ack(press_ack), .use_ext(use_ext), .fault_in(fault_in),
    .test_btn(test_btn), .ext_test(ext_test), .ack_btn(ack_btn), .ext_ack(ext_ack));

  // ****************
  // Bus and check tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Outputs are read at the edge, before that edge's updates land
  task automatic wait_lvl(input int sel, input logic lvl, output int k);
    k = 0;
    while (((sel == 1) ? relay_drive : irq) !== lvl && k < 2000)
    begin
      @(posedge aclk);
      k++;
    end
    // A level that never comes is a failure, not just a long wait
    if (k >= 2000)
      n_mismatch++;
  endtask

  task automatic count_hi(input int k, output int h);
    h = 0;
    repeat (k)
    begin
      @(posedge aclk);
      h += (lamp_out[0] === 1'b1) ? 1 : 0;
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_bvalid === 1'b1)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (s_axi_awready === 1'b1 && !aw_ok)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, exp);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************
  // Clock, watchdog and test sequence
  // ****************
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // The sequence needs about a thousand cycles; this limit only cuts a hang
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    complete_run();
  end

  // Reset clears both synchroniser stages, so two edges of reset are enough
  initial
  begin
    n_mismatch = 0;
    checks = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {want_fault, open_type, press_test, press_ack, use_ext} = '0;
    cyc(2);
    aresetn <= 1'b1;
    rd_chk(ANN_OFF_CTRL, 32'h00000000);
    rd_chk(ANN_OFF_POL, 32'h00000000);
    rd_chk(ANN_OFF_DLY, 32'h00000001);
    rd_chk(ANN_OFF_IMASK, 32'h00000000);
    check(relay_drive, 1'b1);
    wr(ANN_OFF_DLY, 32'h00000201, rsp);
    wr(ANN_OFF_IMASK, 32'h00000001, rsp);
    wr(8'h18, 32'hFFFFFFFF, rsp);
    check(rsp, ANN_RESP_ERR);
    rd(8'h18, rdat, rsp);
    check(rsp, ANN_RESP_ERR);
    check(rdat, 32'h00000000);
    wr(ANN_OFF_STAT, 32'hFFFFFFFF, rsp);
    check(rsp, ANN_RESP_OK);
    want_fault <= 8'h01;
    cyc(6);
    check(ind_out, 8'h01);
    rd_chk(ANN_OFF_STAT, 32'h01000000);
    wait_lvl(0, 1'b1, n);
    wait_lvl(1, 1'b0, n);
    check(n >= 18 && n <= 44, 1'b1);
    check(alarm_out, 1'b1);
    rd_chk(ANN_OFF_STAT, 32'h01030001);
    count_hi(40, hi);
    check(hi, 20);
    want_fault <= 8'h00;
    cyc(40);
    rd_chk(ANN_OFF_STAT, 32'h00030001);
    wr(ANN_OFF_ISTAT, 32'h00000001, rsp);
    cyc(3);
    check(irq, 1'b0);
    want_fault <= 8'h01;
    use_ext <= 1'b1;
    cyc(50);
    press_ack <= 1'b1;
    cyc(1);
    press_ack <= 1'b0;
    wait_lvl(1, 1'b1, n);
    check(n < 60, 1'b1);
    count_hi(40, hi);
    check(hi, 40);
    rd_chk(ANN_OFF_STAT, 32'h01000100);
    want_fault <= 8'h03;
    cyc(100);
    rd_chk(ANN_OFF_STAT, 32'h03030102);
    check(irq, 1'b0);
    rd_chk(ANN_OFF_ISTAT, 32'h00000002);
    use_ext <= 1'b0;
    press_ack <= 1'b1;
    cyc(1);
    press_ack <= 1'b0;
    want_fault <= 8'h00;
    cyc(80);
    rd_chk(ANN_OFF_STAT, 32'h00000000);
    check({lamp_out, relay_drive}, {8'h00, 1'b1});
    wr(ANN_OFF_ISTAT, 32'h00000003, rsp);
    wr(ANN_OFF_CTRL, 32'h00000001, rsp);
    cyc(5);
    check(ind_out, 8'hFF);
    wr(ANN_OFF_CTRL, 32'h00000000, rsp);
    use_ext <= 1'b1;
    press_test <= 1'b1;
    wait_lvl(1, 1'b0, n);
    check({ind_out, lamp_out}, 16'hFFFF);
    rd(ANN_OFF_STAT, rdat, rsp);
    check(rdat & 32'h0000FFFF, 32'h00000000);
    press_test <= 1'b0;
    wait_lvl(1, 1'b1, n);
    check(n < 60, 1'b1);
    wr(ANN_OFF_CTRL, 32'h00000002, rsp);
    use_ext <= 1'b0;
    press_test <= 1'b1;
    cyc(80);
    check({ind_out, relay_drive}, {8'hFF, 1'b1});
    press_test <= 1'b0;
    wr(ANN_OFF_CTRL, 32'h00000004, rsp);
    cyc(5);
    check(ind_out, 8'hFF);
    wr(ANN_OFF_CTRL, 32'h00000000, rsp);
    wr(ANN_OFF_POL, 32'h00000080, rsp);
    open_type <= 8'h80;
    cyc(6);
    check(ind_out, 8'h00);
    want_fault <= 8'h80;
    cyc(6);
    check(ind_out, 8'h80);
    cyc(50);
    rd(ANN_OFF_STAT, rdat, rsp);
    check(rdat & 32'hFF00FFFF, 32'h80000080);
    wr(ANN_OFF_CTRL, 32'h00000008, rsp);
    rd(ANN_OFF_STAT, rdat, rsp);
    check(rdat & 32'hFF00FFFF, 32'h80008000);
    rd_chk(ANN_OFF_CTRL, 32'h00000000);
    complete_run();
  end
endmodule
